// *** verif/return_and_rotate_exec_bench.sv ***
`timescale 1ns/1ps
module return_and_rotate_exec_bench;
  import rrx_pkg::*;
  typedef struct packed {
    logic [13:0] insn;
    logic [7:0]  acc;
    logic        c;
    logic        we;
    logic [7:0]  wd;
  } rrx_row_s;
  localparam rrx_row_s ROWS [6] = '{
    '{14'h0c05, 8'h73, 1'b0, 1'b0, 8'h00}, '{14'h0d86, 8'h73, 1'b1, 1'b1, 8'h02},
    '{14'h0c85, 8'h73, 1'b0, 1'b1, 8'hf3}, '{14'h0d05, 8'he6, 1'b1, 1'b0, 8'h00},
    '{14'h3c10, 8'he6, 1'b1, 1'b0, 8'h00}, '{14'h0c06, 8'h81, 1'b0, 1'b0, 8'h00}};
  logic clock, srst, ce, insn_valid, insn_ready, stack_pop, pc_load, carry;
  logic [13:0] insn;
  logic [12:0] stack_head, pc_value, head;
  logic [7:0]  fdata, acc;
  logic [6:0]  fraddr;
  rrx_fwr_s    fwr;
  int          n_mismatch, comparisons;
  rrx_exec rrx_exec_i (.clock(clock), .srst(srst), .ce(ce), .insn_valid(insn_valid),
    .insn(insn), .stack_head(stack_head), .fdata(fdata), .insn_ready(insn_ready),
    .stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value), .acc(acc),
    .carry(carry), .fwr(fwr), .fraddr(fraddr));
  rrx_core_model rrx_core_model_i (.clock(clock), .fraddr(fraddr), .fwr(fwr),
    .stack_pop(stack_pop), .fdata(fdata), .stack_head(stack_head));
  // ****************************************
  // Compare and report
  // ****************************************
  task automatic chk_vec(input logic [12:0] got, input logic [12:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_vec({12'h000, got}, {12'h000, exp});
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    srst = 1'b1;
    ce = 1'b1;
    insn_valid = 1'b0;
    insn = 14'h0000;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    // Rows go back to back; row i-1 is checked just after the edge that takes it
    for (int i = 0; i <= 6; i++) begin
      @(posedge clock);
      insn_valid <= (i < 6);
      insn <= (i < 6) ? ROWS[i].insn : 14'h0000;
      #1;
      if (i > 0) begin
        chk_vec({5'h00, acc}, {5'h00, ROWS[i-1].acc});
        chk_bit(carry, ROWS[i-1].c);
        chk_bit(fwr.we, ROWS[i-1].we);
        if (ROWS[i-1].we) chk_vec({fwr.addr, fwr.data[5:0]},
          {ROWS[i-1].insn[6:0], ROWS[i-1].wd[5:0]});
        if (ROWS[i-1].we) chk_vec({11'h000, fwr.data[7:6]}, {11'h000, ROWS[i-1].wd[7:6]});
      end
    end
    // Literal return, a rotate in the dead slot, then a plain return
    @(posedge clock);
    head = stack_head;
    insn_valid <= 1'b1;
    insn <= 14'h37a5;
    @(posedge clock);
    insn <= 14'h0d06;
    #1;
    chk_vec({5'h00, acc}, 13'h00a5);
    chk_vec({10'h000, pc_load, stack_pop, insn_ready}, 13'h0006);
    chk_vec(pc_value, head);
    chk_bit(carry, 1'b0);
    @(posedge clock);
    insn <= 14'h0008;
    #1;
    chk_vec({9'h000, fwr.we, pc_load, stack_pop, insn_ready}, 13'h0001);
    chk_vec({5'h00, acc}, 13'h00a5);
    @(posedge clock);
    insn_valid <= 1'b0;
    #1;
    chk_vec({10'h000, pc_load, stack_pop, insn_ready}, 13'h0006);
    chk_vec(pc_value, ~head);
    chk_vec({4'h0, carry, acc}, 13'h00a5);
    @(posedge clock);
    #1;
    chk_vec({10'h000, pc_load, stack_pop, insn_ready}, 13'h0001);
    // Reset in the dead slot of a return clears the visible state
    @(posedge clock);
    insn_valid <= 1'b1;
    insn <= 14'h3411;
    @(posedge clock);
    insn_valid <= 1'b0;
    srst <= 1'b1;
    #1;
    chk_vec({5'h00, acc}, 13'h0011);
    @(posedge clock);
    srst <= 1'b0;
    ce <= 1'b0;
    insn_valid <= 1'b1;
    insn <= 14'h0c05;
    #1;
    chk_vec({4'h0, carry, acc}, 13'h0000);
    chk_vec(pc_value, 13'h0000);
    chk_vec({9'h000, fwr.we, pc_load, stack_pop, insn_ready}, 13'h0001);
    // Clock enable low freezes a rotate offered right after reset
    @(posedge clock);
    ce <= 1'b1;
    #1;
    chk_vec({3'h0, fwr.we, carry, acc}, 13'h0000);
    @(posedge clock);
    insn_valid <= 1'b0;
    #1;
    chk_vec({4'h0, carry, acc}, 13'h0179);
    end_of_test();
  end
endmodule

// *** verif/rrx_core_model.sv ***
`timescale 1ns/1ps
module rrx_core_model (
  input  wire logic              clock,
  input  wire logic [6:0]        fraddr,
  input  wire rrx_pkg::rrx_fwr_s fwr,
  input  wire logic              stack_pop,
  output logic [7:0]             fdata,
  output logic [12:0]            stack_head
);
  import rrx_pkg::*;
  logic [7:0] mem_r [128];
  initial begin
    foreach (mem_r[i]) mem_r[i] = 8'h00;
    mem_r[5] = 8'he6;
    mem_r[6] = 8'h81;
    stack_head = 13'h0a5c;
  end
  // File read is same-cycle; a write still in flight is forwarded so that
  // back-to-back rotates on one register see the new value
  assign fdata = (fwr.we && fwr.addr == fraddr) ? fwr.data : mem_r[fraddr];
  // Inverting head on pop makes two returns in a row see different addresses
  always @(posedge clock) begin
    if (fwr.we) mem_r[fwr.addr] <= fwr.data;
    if (stack_pop) stack_head <= ~stack_head;
  end
endmodule

// *** verilog/rrx_decode.sv ***
`timescale 1ns/1ps
module rrx_decode (
  input  wire logic [13:0]       insn,
  output rrx_pkg::rrx_dec_s      dec
);
  import rrx_pkg::*;

  // ************************************************************
  // Opcode classification
  // ************************************************************
  function automatic logic match(input logic [13:0] w, input logic [13:0] m,
                                 input logic [13:0] p);
    match = ((w & m) == p);
  endfunction

  wire logic is_retlit = match(insn, RETLIT_MASK, RETLIT_PAT);
  wire logic is_return = match(insn, RETURN_MASK, RETURN_PAT);
  wire logic is_rotl   = match(insn, ROT_MASK, ROTL_PAT);
  wire logic is_rotr   = match(insn, ROT_MASK, ROTR_PAT);

  assign dec.op = is_retlit ? RRX_OP_RETLIT :
                  is_return ? RRX_OP_RETURN :
                  is_rotl   ? RRX_OP_ROTL   :
                  is_rotr   ? RRX_OP_ROTR   : RRX_OP_NONE;
  assign dec.dest_file = insn[DEST_BIT];
  assign dec.faddr     = insn[FADDR_LSB +: FADDR_W];
  assign dec.literal   = insn[LIT_LSB +: DATA_W];

endmodule

// *** verilog/rrx_exec.sv ***
`timescale 1ns/1ps
module rrx_exec (
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic              insn_valid,
  input  wire logic [13:0]       insn,
  input  wire logic [12:0]       stack_head,
  input  wire logic [7:0]        fdata,
  output logic                   insn_ready,
  output logic                   stack_pop,
  output logic                   pc_load,
  output logic [12:0]            pc_value,
  output logic [7:0]             acc,
  output logic                   carry,
  output rrx_pkg::rrx_fwr_s      fwr,
  output logic [6:0]             fraddr
);
  import rrx_pkg::*;

  // ************************************************************
  // Decode
  // ************************************************************
  rrx_dec_s dec;

  rrx_decode u_dec (
    .insn (insn),
    .dec  (dec)
  );

  typedef enum logic [0:0] {
    RRX_ST_RUN  = 1'b0,
    RRX_ST_WAIT = 1'b1
  } rrx_st_e;

  rrx_st_e     st_r, st_nxt;
  logic [7:0]  acc_r;
  logic        carry_r;
  logic        pop_r;
  logic        pcl_r;
  logic [12:0] pc_r;
  logic        rdy_r;
  rrx_fwr_s    fwr_r;

  // File read address is combinational so fdata is valid in the issue cycle
  // Back-to-back use of one register relies on the file forwarding fwr
  assign fraddr = dec.faddr;

  wire logic take      = ce && insn_valid && (st_r == RRX_ST_RUN);
  wire logic do_retlit = take && (dec.op == RRX_OP_RETLIT);
  wire logic do_return = take && (dec.op == RRX_OP_RETURN);
  wire logic do_ret    = do_retlit || do_return;
  wire logic do_rotl   = take && (dec.op == RRX_OP_ROTL);
  wire logic do_rotr   = take && (dec.op == RRX_OP_ROTR);
  wire logic do_rot    = do_rotl || do_rotr;

  // ************************************************************
  // Rotate datapath
  // ************************************************************
  wire logic [7:0] rotl_val = {fdata[6:0], carry_r};
  wire logic [7:0] rotr_val = {carry_r, fdata[7:1]};
  wire logic [7:0] rot_val  = do_rotl ? rotl_val : rotr_val;
  wire logic       rot_cout = do_rotl ? fdata[7] : fdata[0];

  wire logic [7:0] acc_nxt =
    do_retlit                     ? dec.literal :
    (do_rot && !dec.dest_file)    ? rot_val     :
                                    acc_r;
  wire logic carry_nxt = do_rot ? rot_cout : carry_r;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      RRX_ST_RUN:  if (do_ret) st_nxt = RRX_ST_WAIT;
      RRX_ST_WAIT: if (ce) st_nxt = RRX_ST_RUN;
    endcase
  end

  // ************************************************************
  // State
  // ************************************************************
  // Control: sequencing and the stack and program counter handshake
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r  <= RRX_ST_RUN;
      pop_r <= 1'b0;
      pcl_r <= 1'b0;
      pc_r  <= PC_RST;
      rdy_r <= 1'b1;
    end else if (ce) begin
      st_r  <= st_nxt;
      pop_r <= do_ret;
      pcl_r <= do_ret;
      if (do_ret) begin
        pc_r <= stack_head;
      end
      // Second cycle of a return is a dead slot
      rdy_r <= (st_nxt == RRX_ST_RUN);
    end
  end

  // Accumulator and carry
  always_ff @(posedge clock) begin
    if (srst) begin
      acc_r   <= ACC_RST;
      carry_r <= CARRY_RST;
    end else if (ce) begin
      acc_r   <= acc_nxt;
      carry_r <= carry_nxt;
    end
  end

  // File write-back, one pulse per rotate that targets the file
  always_ff @(posedge clock) begin
    if (srst) begin
      fwr_r <= '0;
    end else if (ce) begin
      fwr_r.we   <= do_rot && dec.dest_file;
      fwr_r.addr <= dec.faddr;
      fwr_r.data <= rot_val;
    end
  end

  assign insn_ready = rdy_r;
  assign stack_pop  = pop_r;
  assign pc_load    = pcl_r;
  assign pc_value   = pc_r;
  assign acc        = acc_r;
  assign carry      = carry_r;
  assign fwr        = fwr_r;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_ret_issue;
    ce && insn_valid && st_r == RRX_ST_RUN && dec.op == RRX_OP_RETLIT;
  endsequence

  a_retlit_acc_load: assert property (
    s_ret_issue |=> acc == $past(dec.literal) && carry == $past(carry_r))
    else $error("literal return did not load accumulator");

  a_retlit_pc_load: assert property (
    s_ret_issue |=> pc_load && pc_value == $past(stack_head) && !insn_ready)
    else $error("literal return did not reload pc");

  a_return_pop: assert property (
    do_return |=> stack_pop && pc_load && carry == $past(carry_r) && acc == $past(acc_r))
    else $error("return did not pop stack");

  a_ret_two_cyc: assert property (
    (do_ret ##1 ce) |=> insn_ready)
    else $error("return took wrong cycle count");

  a_rotl_value: assert property (
    do_rotl |=> carry == $past(fdata[7]))
    else $error("left rotate carry out wrong");

  a_rotl_dest: assert property (
    do_rotl && dec.dest_file |=> fwr.we && fwr.data == {$past(fdata[6:0]), $past(carry_r)})
    else $error("left rotate file write wrong");

  a_rotr_value: assert property (
    do_rotr |=> carry == $past(fdata[0]))
    else $error("right rotate carry out wrong");

  a_rotr_acc: assert property (
    do_rotr && !dec.dest_file |=> !fwr.we && acc == {$past(carry_r), $past(fdata[7:1])})
    else $error("right rotate accumulator write wrong");

  a_rotl_in_bit: assert property (
    do_rotl && !dec.dest_file |=> acc[0] == $past(carry_r))
    else $error("left rotate carry-in bit wrong");

  // Dead slot after a return: no pulse, no write, ready again
  sequence s_dead_slot;
    ce && st_r == RRX_ST_WAIT;
  endsequence

  a_dead_slot_idle: assert property (
    s_dead_slot |=> !stack_pop && !pc_load && !fwr.we && insn_ready && acc == $past(acc_r))
    else $error("dead slot after return not idle");

  a_return_dead_slot: assert property (
    do_return |=> !insn_ready)
    else $error("return did not insert dead slot");

  a_retlit_pop: assert property (
    do_retlit |=> stack_pop && !fwr.we)
    else $error("literal return did not pop stack");

  a_rot_one_cyc: assert property (
    do_rot |=> insn_ready && !stack_pop && !pc_load)
    else $error("rotate took more than one cycle");

  a_rotl_acc: assert property (
    do_rotl && !dec.dest_file |=> !fwr.we && acc == {$past(fdata[6:0]), $past(carry_r)})
    else $error("left rotate accumulator write wrong");

  a_rotl_file_keep: assert property (
    do_rotl && dec.dest_file |=> fwr.addr == $past(dec.faddr) && acc == $past(acc_r))
    else $error("left rotate to file touched accumulator");

  a_rotr_file: assert property (
    do_rotr && dec.dest_file |=> fwr.we && fwr.addr == $past(dec.faddr) &&
      fwr.data == {$past(carry_r), $past(fdata[7:1])} && acc == $past(acc_r))
    else $error("right rotate file write wrong");

  a_no_stray_write: assert property (
    ce && !(do_rot && dec.dest_file) |=> !fwr.we)
    else $error("file written without rotate to file");

  a_rotr_in_bit: assert property (
    do_rotr && !dec.dest_file |=> acc[7] == $past(carry_r))
    else $error("right rotate carry-in bit wrong");

endmodule

// *** verilog/rrx_pkg.sv ***
package rrx_pkg;

  // ************************************************************
  // Instruction word layout
  // ************************************************************
  localparam int unsigned INSN_W     = 14;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FADDR_W    = 7;
  localparam int unsigned PC_W       = 13;
  localparam int unsigned DEST_BIT   = 7;
  localparam int unsigned LIT_LSB    = 0;
  localparam int unsigned FADDR_LSB  = 0;

  // Opcode match patterns and masks
  localparam logic [13:0] RETLIT_MASK = 14'h3c00;
  localparam logic [13:0] RETLIT_PAT  = 14'h3400;
  localparam logic [13:0] RETURN_MASK = 14'h3fff;
  localparam logic [13:0] RETURN_PAT  = 14'h0008;
  localparam logic [13:0] ROT_MASK    = 14'h3f00;
  localparam logic [13:0] ROTL_PAT    = 14'h0d00;
  localparam logic [13:0] ROTR_PAT    = 14'h0c00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned RET_CYCLES = 2;
  localparam int unsigned ROT_CYCLES = 1;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [12:0] PC_RST    = 13'h0000;
  localparam logic        CARRY_RST = 1'b0;

  typedef enum logic [2:0] {
    RRX_OP_NONE   = 3'b000,
    RRX_OP_RETLIT = 3'b001,
    RRX_OP_RETURN = 3'b010,
    RRX_OP_ROTL   = 3'b011,
    RRX_OP_ROTR   = 3'b100
  } rrx_op_e;

  // Decoded instruction fields
  typedef struct packed {
    rrx_op_e      op;
    logic         dest_file;
    logic [6:0]   faddr;
    logic [7:0]   literal;
  } rrx_dec_s;

  // Write-back to the file register array
  typedef struct packed {
    logic         we;
    logic [6:0]   addr;
    logic [7:0]   data;
  } rrx_fwr_s;

endpackage
